//--- bench/wir_master_model.sv
// two-wire bus master model, 48 ns clock, open-drain data
`timescale 1ns/100ps
module wir_master_model (
    input  wire sdaWire,  // resolved data line
    output reg  scl,      // serial clock, still outside frames
    output reg  sdaM      // master data drive, 1 releases to pull-up
);
    // clock low 28 ns, high 20 ns: the ack release crosses the clock
    // synchroniser, so the low phase takes the larger share
    initial begin
        scl = 1'b1;   // idle high
        sdaM = 1'b1;
    end
    // start, also repeated start from clock low
    task startCond;
        begin
            #12 sdaM <= 1'b1;
            #16 scl <= 1'b1;
            #20 sdaM <= 1'b0;
            #20 scl <= 1'b0;
        end
    endtask
    // stop, then bus left idle
    task stopCond;
        begin
            #12 sdaM <= 1'b0;
            #16 scl <= 1'b1;
            #20 sdaM <= 1'b1;
            #20;
        end
    endtask
    // n bits msb first, ninth clock samples ack when n is 8
    task sendByte(input [7:0] b, input integer n, output reg ack);
        integer i;
        begin
            ack = 1'b1;
            for (i = 0; i < n; i = i + 1) begin
                #12 sdaM <= b[7-i]; // change only while clock low
                #16 scl <= 1'b1;
                #20 scl <= 1'b0;
            end
            if (n == 8) begin
                #12 sdaM <= 1'b1; // release for the ack
                #16 scl <= 1'b1;
                #11 ack = sdaWire;
                #9 scl <= 1'b0;
            end
        end
    endtask
endmodule // wir_master_model

//--- bench/wir_port_monitor.sv
// assertions on the write-only serial settings port
`timescale 1ns/100ps
module wir_port_monitor #(
    parameter NREG = 4  // settings register count
) (
    input wire       mclk,
    input wire       reset_n,
    input wire       supplyLow,
    input wire       chipEnableInput,
    input wire       sclIn,
    input wire       sdaIn,
    input wire       sdaOut,
    input wire       sdaOe,
    input wire [7:0] setting0,
    input wire [7:0] setting1,
    input wire [7:0] setting2,
    input wire [7:0] setting3,
    input wire       outputsActive,
    input wire       writeStrobe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire [31:0] allSet = {setting3, setting2, setting1, setting0}; // all settings
    sequence ackClk; $rose(sclIn) && sdaOe; endsequence // ninth clock rises under ack
    sequence busIdle; (sclIn && sdaIn)[*8]; endsequence // both lines resting high
    open_drain_a: assert property (sdaOe |-> !sdaOut)
        else $error("data driven high");
    // the clock fall reaches the ack logic through the synchroniser,
    // so the pin must have been low five cycles before the ack edge
    ack_start_a: assert property ($rose(sdaOe) |-> !$past(sclIn, 5))
        else $error("ack with clock high");
    ack_hold_a: assert property (ackClk |=> sdaOe[*3])
        else $error("ack dropped early");
    ack_end_a: assert property ($rose(sdaOe) |-> ##[6:14] $fell(sdaOe))
        else $error("ack too long");
    ack_drop_a: assert property ($fell(sdaOe) |-> !$past(sclIn, 5))
        else $error("ack freed high");
    strobe_gap_a: assert property (writeStrobe |=> !writeStrobe[*8])
        else $error("strobe");
    set_cause_a: assert property ($changed(allSet) |-> writeStrobe || $past(supplyLow))
        else $error("setting changed alone");
    supply_clear_a: assert property (supplyLow |=> allSet == 32'h0)
        else $error("no clear");
    out_gate_a: assert property (outputsActive |-> $past(setting0[7]))
        else $error("out on");
    // a quiet bus must not start an ack in the following cycle
    idle_quiet_a: assert property (busIdle |=> !sdaOe)
        else $error("drive on idle bus");
endmodule // wir_port_monitor
bind wir_port wir_port_monitor #(.NREG(NREG)) u_wir_port_monitor (.mclk(mclk),
    .reset_n(reset_n), .supplyLow(supplyLow), .chipEnableInput(chipEnableInput),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .setting0(setting0),
    .setting1(setting1), .setting2(setting2), .setting3(setting3),
    .outputsActive(outputsActive), .writeStrobe(writeStrobe));

//--- bench/write_only_i2c_register_port_tb_top.sv
// self-checking bench for the serial settings port
`timescale 1ns/100ps
module write_only_i2c_register_port_tb_top;
    reg mclk, reset_n, supplyLow, chipEnableInput; // bench-driven inputs
    wire scl, sdaM, sdaOut, sdaOe, outputsActive, writeStrobe;
    wire [7:0] s0, s1, s2, s3; // settings outputs
    wire sdaIn = sdaOe ? sdaOut : sdaM; // open-drain wire, pulled up
    reg [7:0] ex [0:3]; // expected settings
    integer fail_count, checks, strobes, expStrobes, cyc, i;
    reg [31:0] seed, r;
    wir_port u_wir_port (.mclk(mclk), .reset_n(reset_n), .supplyLow(supplyLow),
        .chipEnableInput(chipEnableInput), .sclIn(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .setting0(s0), .setting1(s1), .setting2(s2), .setting3(s3),
        .outputsActive(outputsActive), .writeStrobe(writeStrobe));
    wir_master_model master (.sdaWire(sdaIn), .scl(scl), .sdaM(sdaM));
    always #2.5 mclk = ~mclk;
    // strobe count and hang guard
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (writeStrobe === 1'b1) strobes = strobes + 1;
        if (cyc == 30000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end
    function [1:0] nextPtr(input [1:0] p);
        nextPtr = (p == 2'h3) ? 2'h0 : p + 2'h1;
    endfunction
    task check(input ok, input [8*16-1:0] msg);
        begin
            checks = checks + 1;
            if (!ok) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED at %0t: %0s", $time, msg);
            end
        end
    endtask
    task regsCheck;
        begin
            repeat (8) @(posedge mclk);
            check({s3, s2, s1, s0} === {ex[3], ex[2], ex[1], ex[0]}, "settings");
            check(strobes === expStrobes, "strobe count");
            check(outputsActive === (chipEnableInput & ex[0][7]), "output gate");
        end
    endtask
    // one access: address, pointer, n data bytes, stop
    task writeSeq(input [7:0] addr, input [7:0] ptr, input integer n, input ok);
        integer k;
        reg [7:0] d;
        reg [1:0] p;
        reg a;
        begin
            p = ptr[1:0];
            master.startCond;
            master.sendByte(addr, 8, a);
            check(a === !ok, "address ack");
            master.sendByte(ptr, 8, a);
            check(a === !ok, "pointer ack");
            for (k = 0; k < n; k = k + 1) begin
                d = $random(seed);
                master.sendByte(d, 8, a);
                check(a === !ok, "data ack");
                if (ok) begin
                    ex[p] = d;
                    p = nextPtr(p);
                    expStrobes = expStrobes + 1;
                end
            end
            master.stopCond;
            regsCheck;
        end
    endtask
    task print_verdict;
        begin
            $display("checks=%0d fail_count=%0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        supplyLow = 1'b0;
        chipEnableInput = 1'b0;
        {fail_count, checks, strobes, expStrobes, cyc} = 0;
        seed = 32'h14c9b2d3;
        for (i = 0; i < 4; i = i + 1) ex[i] = 8'h00;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        regsCheck;
        writeSeq(8'he4, 8'hff, 6, 1'b1);
        for (i = 0; i < 6; i = i + 1) begin
            r = $random(seed);
            chipEnableInput <= r[31];
            writeSeq(8'he4, r[7:0], 1 + r[10:8], 1'b1);
        end
        writeSeq(8'he5, 8'h01, 2, 1'b0);
        writeSeq(8'he6, 8'h02, 1, 1'b0);
        writeSeq({(r[22:16] == 7'h72) ? 7'h73 : r[22:16], 1'b0}, 8'h00, 2, 1'b0);
        master.startCond;
        master.sendByte(8'he4, 8, r[0]);
        master.sendByte(8'h02, 8, r[0]);
        master.sendByte(8'h5a, 5, r[0]);
        writeSeq(8'he4, 8'h01, 1, 1'b1);
        master.startCond;
        master.sendByte(8'he4, 8, r[0]);
        master.sendByte(8'h03, 8, r[0]);
        master.sendByte(8'ha5, 4, r[0]);
        master.stopCond;
        regsCheck;
        supplyLow <= 1'b1;
        repeat (3) @(posedge mclk);
        supplyLow <= 1'b0;
        for (i = 0; i < 4; i = i + 1) ex[i] = 8'h00;
        regsCheck;
        print_verdict;
    end
endmodule // write_only_i2c_register_port_tb_top

//--- design/wir_port.v
// write-only two-wire target port with four settings registers
//
// Notes on behaviour
// - idle bus: both lines rest high
// - data falls while clock high: start
// - data rises while clock high: stop
// - transfers move in whole eight-bit bytes
// - any number of bytes until stop
// - receiver pulls data low to acknowledge
// - release data at ninth clock fall
// - first byte: address msb first, write bit
// - write only, no readable data
// - answer only the fixed target address
// - second byte is the register pointer
// - third byte stored at pointed register
// - later bytes: pointer increments before store
// - pointer wraps from last register to zero
// - byte takes effect at lsb rising clock
// - writes accepted while chip enable low
// - supply drop resets all settings
`timescale 1ns/100ps
`include "wir_regs.vh"
module wir_port #(
    parameter NREG = `WIR_NUM_REGS  // number of settings registers
) (
    mclk,
    reset_n,
    supplyLow,
    chipEnableInput,
    sclIn,
    sdaIn,
    sdaOut,
    sdaOe,
    setting0,
    setting1,
    setting2,
    setting3,
    outputsActive,
    writeStrobe
);
    input  wire       mclk;            // 200 MHz system clock
    input  wire       reset_n;         // asynchronous reset, active low
    input  wire       supplyLow;       // logic supply low, same domain
    input  wire       chipEnableInput; // chip enable level, pin
    input  wire       sclIn;           // serial clock pin level
    input  wire       sdaIn;           // serial data pin level
    output reg        sdaOut;          // data pin drive value
    output reg        sdaOe;           // data pin enable, high drives
    output reg  [7:0] setting0;        // settings register 0
    output reg  [7:0] setting1;        // settings register 1
    output reg  [7:0] setting2;        // settings register 2
    output reg  [7:0] setting3;        // settings register 3
    output reg        outputsActive;   // enable pin high and bit 7 set
    output reg        writeStrobe;     // one-cycle pulse per stored byte

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;  // waiting for start
    localparam ST_ADDR = 2'h1;  // receiving address byte
    localparam ST_DATA = 2'h2;  // receiving pointer or data
    localparam ST_IGN  = 2'h3;  // not addressed, ignore

    wire       scl;             // filtered clock
    wire       sda;             // filtered data
    wire       ena;             // filtered chip enable
    reg        sclPrev_r;       // clock one cycle ago
    reg        sdaPrev_r;       // data one cycle ago
    reg  [1:0] state_r;         // protocol state
    reg  [3:0] bitCnt_r;        // bits taken in this byte
    reg  [6:0] shift_r;         // first seven bits of the byte
    reg        ackPend_r;       // drive ack at next clock fall
    reg        ackOn_r;         // ack is being driven
    reg  [1:0] byteIdx_r;       // 0 pointer, 1 first data, 2 later
    reg  [1:0] ptr_r;           // register pointer

    wire sclRise  = scl & ~sclPrev_r;
    wire sclFall  = ~scl & sclPrev_r;
    wire startEv  = scl & sclPrev_r & sdaPrev_r & ~sda;
    wire stopEv   = scl & sclPrev_r & ~sdaPrev_r & sda;
    wire lastBit  = (bitCnt_r == `WIR_BITS_PER_BYTE - 4'h1);
    wire [7:0] fullByte = {shift_r, sda};

    // next pointer with wrap after last register
    function [1:0] nextPtr;
        input [1:0] p;
        begin
            nextPtr = (p == `WIR_LAST_REG) ? 2'h0 : p + 2'h1;
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wir_sync u_scl (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .async_in  (sclIn),
        .level_out (scl)
    );
    wir_sync u_sda (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .async_in  (sdaIn),
        .level_out (sda)
    );
    wir_sync u_ena (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .async_in  (chipEnableInput),
        .level_out (ena)
    );

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclPrev_r     <= 1'b1;
            sdaPrev_r     <= 1'b1;
            state_r       <= ST_IDLE;
            bitCnt_r      <= 4'h0;
            shift_r       <= 7'h00;
            ackPend_r     <= 1'b0;
            ackOn_r       <= 1'b0;
            byteIdx_r     <= 2'h0;
            ptr_r         <= 2'h0;
            sdaOut        <= 1'b0;
            sdaOe         <= 1'b0;
            setting0      <= `WIR_SET_RESET;
            setting1      <= `WIR_SET_RESET;
            setting2      <= `WIR_SET_RESET;
            setting3      <= `WIR_SET_RESET;
            outputsActive <= 1'b0;
            writeStrobe   <= 1'b0;
        end else begin
            sclPrev_r     <= scl;
            sdaPrev_r     <= sda;
            sdaOut        <= 1'b0;
            writeStrobe   <= 1'b0;
            // enable pin only gates outputs, never the writes
            outputsActive <= ena & setting0[7];
            if (supplyLow) begin
                // supply drop clears every setting
                setting0  <= `WIR_SET_RESET;
                setting1  <= `WIR_SET_RESET;
                setting2  <= `WIR_SET_RESET;
                setting3  <= `WIR_SET_RESET;
                state_r   <= ST_IDLE;
                ackPend_r <= 1'b0;
                ackOn_r   <= 1'b0;
                sdaOe     <= 1'b0;
                outputsActive <= 1'b0;
            end else if (startEv) begin
                // start or repeated start drops any partial byte
                state_r   <= ST_ADDR;
                bitCnt_r  <= 4'h0;
                ackPend_r <= 1'b0;
                ackOn_r   <= 1'b0;
                sdaOe     <= 1'b0;
            end else if (stopEv) begin
                // stop ends access, partial byte discarded
                state_r   <= ST_IDLE;
                ackPend_r <= 1'b0;
                ackOn_r   <= 1'b0;
                sdaOe     <= 1'b0;
            end else begin
                // ack window: drive after 8th fall, release at 9th
                if (sclFall && ackPend_r) begin
                    ackPend_r <= 1'b0;
                    ackOn_r   <= 1'b1;
                    sdaOe     <= 1'b1;
                end else if (sclFall && ackOn_r) begin
                    ackOn_r <= 1'b0;
                    sdaOe   <= 1'b0;
                end
                // bit sampling on clock rise, skipping the ack clock
                if (sclRise && !ackOn_r && (state_r == ST_ADDR || state_r == ST_DATA)) begin
                    shift_r  <= {shift_r[5:0], sda};
                    bitCnt_r <= lastBit ? 4'h0 : bitCnt_r + 4'h1;
                    if (lastBit) begin
                        case (state_r)
                            ST_ADDR: begin
                                // address msb first then write bit
                                if (fullByte[7:1] == `WIR_TARGET_ADDR &&
                                    fullByte[0] == `WIR_DIR_WRITE) begin
                                    state_r   <= ST_DATA;
                                    byteIdx_r <= 2'h0;
                                    ackPend_r <= 1'b1;
                                end else begin
                                    state_r <= ST_IGN;
                                end
                            end
                            ST_DATA: begin
                                ackPend_r <= 1'b1;
                                if (byteIdx_r == 2'h0) begin
                                    ptr_r     <= fullByte[1:0];
                                    byteIdx_r <= 2'h1;
                                end else begin
                                    // store on the lsb rising edge
                                    writeStrobe <= 1'b1;
                                    if (byteIdx_r == 2'h1) begin
                                        byteIdx_r <= 2'h2;
                                        case (ptr_r)
                                            2'h0:    setting0 <= fullByte;
                                            2'h1:    setting1 <= fullByte;
                                            2'h2:    setting2 <= fullByte;
                                            default: setting3 <= fullByte;
                                        endcase
                                    end else begin
                                        ptr_r <= nextPtr(ptr_r);
                                        case (nextPtr(ptr_r))
                                            2'h0:    setting0 <= fullByte;
                                            2'h1:    setting1 <= fullByte;
                                            2'h2:    setting2 <= fullByte;
                                            default: setting3 <= fullByte;
                                        endcase
                                    end
                                end
                            end
                            default: state_r <= ST_IGN;
                        endcase
                    end
                end
            end
        end
    end
endmodule // wir_port

//--- design/wir_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module wir_sync (
    mclk,
    reset_n,
    async_in,
    level_out
);
    input  wire mclk;       // system clock
    input  wire reset_n;    // asynchronous reset, active low
    input  wire async_in;   // pin from outside the clock domain
    output reg  level_out;  // filtered level

    reg s1_r;  // first stage, read by s2 only
    reg s2_r;  // second stage
    reg s3_r;  // third stage

    // ------------------------------------------------------------
    // sync chain
    // ------------------------------------------------------------
    // chain resets high, matching an idle bus
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r      <= 1'b1;
            s2_r      <= 1'b1;
            s3_r      <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // change counts once stages two and three agree
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule // wir_sync

//--- include/wir_regs.vh
// constants for the write-only serial settings port
`ifndef WIR_REGS_VH
`define WIR_REGS_VH
`define WIR_TARGET_ADDR   7'h72
`define WIR_NUM_REGS      4
`define WIR_LAST_REG      2'h3
`define WIR_SET_RESET     8'h00
`define WIR_BITS_PER_BYTE 4'h8
`define WIR_DIR_WRITE     1'b0
`endif
